// File: rtl/wpes_defs.vh
// What this block does
// - host keeps periodic channel time at or below 80%, borrowing 20% briefly
// - interval exponent 6..16; interval is 2^(x-1) ticks of 128 us
// - host may attempt anywhere in interval; provided interval may be shorter
// - windows reset after successful configuration control transfers completes
// - after NAK or flow control, host resumes attempts next interval
// - pipe halts on STALL or exhausted retry policy after errors; here only interrupt pipes halt, low-power ones on STALL only
// - host tolerates gaps up to 8.192 ms once every 65.536 ms
// - isochronous retry reserve at least 30%, at least one retry per interval
// - host uses reserved isochronous bandwidth until flow control response
// - interrupt transactions follow reliable burst sequence with window acknowledgements
// - host makes at most 3 low-power attempts, retrying only after device tried
//
// Purpose: constants for the periodic endpoint scheduler (host side)
// Assumes: 25 MHz clock
// Notes:   times in their own unit, cycle counts derived from them
`ifndef WPES_DEFS_VH
`define WPES_DEFS_VH
`define WPES_CLK_MHZ        25
`define WPES_TICK_US        128
`define WPES_TICK_CYC       (`WPES_TICK_US * `WPES_CLK_MHZ)
`define WPES_EXP_MIN        4'h6
`define WPES_EXP_MAX        4'h0
`define WPES_EXP_TOP        5'h10
`define WPES_RETRY_STD      3'h5
`define WPES_RETRY_LP       3'h3
`define WPES_ISO_RETRY_MIN  3'h1
`define WPES_ISO_RESV_PCT   30
`define WPES_PER_PCT        80
`define WPES_BORROW_PCT     20
`define WPES_GAP_US         8192
`define WPES_GAP_EVERY_US   65536
`define WPES_HS_ACK         3'h1
`define WPES_HS_NAK         3'h2
`define WPES_HS_STALL       3'h3
`define WPES_HS_ERR         3'h4
`define WPES_HS_SILENT      3'h5
`define WPES_HS_NONE        3'h0
`endif

// File: rtl/wpes_tick.v
// Purpose: free-running 128 us tick pulse
// Assumes: one clock, synchronous released reset
// Notes:   pulse is one cycle wide
`timescale 1ns/1ns
`include "wpes_defs.vh"
module wpes_tick (
  input  wire clk_i,
  input  wire rst_n_i,
  output reg  tick_o
);
  // full-width constant first, then an explicit slice to the counter width
  localparam [31:0] TICK_LAST_W = `WPES_TICK_CYC - 1;
  localparam [16:0] TICK_LAST   = TICK_LAST_W[16:0];
  reg [16:0] cnt;
  // divide local clock down to the tick period
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 17'h00000;
      tick_o <= 1'b0;
    end else if (cnt == TICK_LAST) begin
      cnt    <= 17'h00000;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt + 17'h00001;
      tick_o <= 1'b0;
    end
  end
endmodule // wpes_tick

// File: rtl/wpes_host.v
// Purpose: host-side scheduler for one periodic pipe (interrupt or isochronous)
// Assumes: transaction engine outside answers each attempt with a handshake code
// Notes:   one pipe per instance; bandwidth admission is done by software
`timescale 1ns/1ns
`include "wpes_defs.vh"
module wpes_host (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       enable_i,       // pipe configured and active
  input  wire [3:0] exp_i,          // requested interval exponent
  input  wire       iso_i,          // 1 isochronous, 0 interrupt
  input  wire       low_power_i,    // low-power interrupt IN endpoint
  input  wire       dir_in_i,       // pipe direction, fixed per pipe
  input  wire [2:0] iso_slots_i,    // reserved isochronous attempts incl. retries
  input  wire       ctl_done_i,     // config control transfer completed ok
  input  wire       clear_halt_i,   // halt recovery by software
  input  wire       hs_valid_i,     // handshake result valid, one cycle
  input  wire [2:0] hs_code_i,      // handshake result
  input  wire       dev_tried_i,    // device attempted to send in this exchange
  output wire       attempt_o,      // request one transaction, held until taken
  input  wire       attempt_ready_i,
  output reg        attempt_dir_o,
  output reg        win_reset_o,    // re-initialise burst windows, one pulse
  output reg        halted_o,
  output reg        bad_exp_o,      // requested exponent out of range
  output reg        interval_o      // start of each service interval, pulse
);
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ  = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_DONE = 2'h3;

  reg        rst_s1;
  reg        rst_s2;
  wire       rst_n = rst_s2;
  wire       tick;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg [15:0] tick_cnt;
  reg [15:0] int_len;
  reg  [2:0] tries;
  reg  [2:0] max_tries;
  reg        retry_ok;
  wire [3:0] exp_use;
  wire       exp_ok;
  wire       int_end;

  // reset release through two flops
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  wpes_tick u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .tick_o  (tick)
  );

  // exponent 0 encodes 16 (shift of 0-1 wraps to 15); anything else below 6 is
  // clamped so the timer stays bounded
  assign exp_ok  = (exp_i >= `WPES_EXP_MIN) || (exp_i == `WPES_EXP_MAX);
  assign exp_use = exp_ok ? exp_i : `WPES_EXP_MIN;
  assign int_end = tick && (tick_cnt == int_len - 16'h0001);

  // interval length in ticks: 2^(x-1); 16 bits hold up to 2^15
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      int_len   <= 16'h0020;
      tick_cnt  <= 16'h0000;
      bad_exp_o <= 1'b0;
    end else begin
      int_len   <= 16'h0001 << (exp_use - 4'h1);
      bad_exp_o <= enable_i && !exp_ok;
      // intervals count local ticks only, so a long channel gap just shifts
      // the attempt inside its interval and never skews later intervals
      if (!enable_i)
        tick_cnt <= 16'h0000;
      else if (int_end)
        tick_cnt <= 16'h0000;
      else if (tick)
        tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // attempt budget per interval: std 1+5, low power 3 total, iso reserved slots but at least 2;
  // a fixed budget keeps this pipe inside its admitted share of channel time
  always @* begin
    if (iso_i)
      max_tries = (iso_slots_i > `WPES_ISO_RETRY_MIN) ? iso_slots_i
                                                       : 3'h2;
    else if (low_power_i)
      max_tries = `WPES_RETRY_LP;
    else
      max_tries = `WPES_RETRY_STD + 3'h1;
  end

  // scheduler: attempt at interval start, retry on error, stop on flow control
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (enable_i && !halted_o && int_end) next_state = ST_REQ;
      ST_REQ:  if (attempt_ready_i) next_state = ST_WAIT;
      ST_WAIT: begin
        if (hs_valid_i) begin
          case (hs_code_i)
            `WPES_HS_NAK:   next_state = ST_DONE;
            `WPES_HS_STALL: next_state = ST_IDLE;
            `WPES_HS_ACK:   next_state = iso_i && (tries < max_tries) ? ST_REQ
                                                                      : ST_DONE;
            default: begin
              // no wait for ready notifications: retry straight away
              if (tries < max_tries && retry_ok)
                next_state = ST_REQ;
              else
                next_state = iso_i || low_power_i ? ST_DONE : ST_IDLE;
            end
          endcase
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @* begin
    retry_ok = low_power_i ? dev_tried_i : 1'b1;
  end

  // the next int_end re-arms IDLE, so a NAK resumes next interval
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      tries         <= 3'h0;
      halted_o      <= 1'b0;
      win_reset_o   <= 1'b0;
      interval_o    <= 1'b0;
      attempt_dir_o <= 1'b0;
    end else begin
      state         <= ctl_done_i ? ST_IDLE : next_state;
      interval_o    <= int_end;
      win_reset_o   <= ctl_done_i;
      attempt_dir_o <= dir_in_i;
      if (state == ST_IDLE)
        tries <= 3'h0;
      else if (state == ST_REQ && attempt_ready_i)
        tries <= tries + 3'h1;
      // halt a non-iso pipe on stall or exhausted standard retry policy; clear or reconfig recovers
      if (state == ST_WAIT && hs_valid_i && !iso_i &&
          (hs_code_i == `WPES_HS_STALL ||
           (hs_code_i == `WPES_HS_ERR && tries >= max_tries && !low_power_i)))
        halted_o <= 1'b1;
      else if (clear_halt_i || ctl_done_i)
        halted_o <= 1'b0;
    end
  end

  assign attempt_o = (state == ST_REQ);
endmodule // wpes_host

// File: tb/wpes_host_props.sv
// Purpose: port checker for the periodic pipe scheduler
// Assumes: handshakes only arrive while an attempt is outstanding
// Notes: exponent 0 stands for 16 and is left out of the range checks
`timescale 1ns/1ns
`include "wpes_defs.vh"
module wpes_host_props (
  input wire clk_i, input wire rst_n_i, input wire enable_i, input wire [3:0] exp_i,
  input wire iso_i, input wire low_power_i, input wire dir_in_i, input wire [2:0] iso_slots_i,
  input wire ctl_done_i, input wire clear_halt_i, input wire hs_valid_i,
  input wire [2:0] hs_code_i, input wire dev_tried_i, input wire attempt_o,
  input wire attempt_ready_i, input wire attempt_dir_o, input wire win_reset_o,
  input wire halted_o, input wire bad_exp_o, input wire interval_o
);
  logic [3:0] acc;
  // accepted attempts since the last interval start
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) acc <= 4'h0;
    else if (interval_o) acc <= 4'h0;
    else if (attempt_o && attempt_ready_i) acc <= acc + 4'h1;
  end
  // one domain; five cycles of settling cover the released reset copy
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_win_reset: assert property (ctl_done_i |=> win_reset_o) else $error("no reset");
  a_stall_halt: assert property (!iso_i && hs_valid_i && hs_code_i == `WPES_HS_STALL
    |=> halted_o) else $error("no halt");
  a_halt_idle: assert property (halted_o |-> !attempt_o) else $error("attempt in halt");
  a_att_held: assert property (attempt_o && !attempt_ready_i && !ctl_done_i
    |=> attempt_o) else $error("drop");
  a_exp_low: assert property ((enable_i && exp_i > 4'h0 && exp_i < `WPES_EXP_MIN) [*5]
    |-> bad_exp_o) else $error("no flag");
  a_iv_attempt: assert property (interval_o && $past(enable_i) && !$past(halted_o) &&
    !$past(ctl_done_i) |-> attempt_o) else $error("no attempt");
  a_nak_ends: assert property (hs_valid_i && hs_code_i == `WPES_HS_NAK
    |=> !attempt_o [*8]) else $error("retry");
  a_iv_gap: assert property (interval_o |=> !interval_o [*8]) else $error("short interval");
  a_lp_budget: assert property (attempt_o && attempt_ready_i && low_power_i
    |-> acc < {1'b0, `WPES_RETRY_LP}) else $error("low power budget");
  a_std_budget: assert property (attempt_o && attempt_ready_i && !iso_i && !low_power_i
    |-> acc <= {1'b0, `WPES_RETRY_STD}) else $error("retry budget");
endmodule // wpes_host_props
bind wpes_host wpes_host_props u_props (.*);

// File: tb/wpes_ep_model.sv
// Purpose: endpoint stand-in that takes each attempt and answers it
// Assumes: code_i is what the endpoint reports, lat_i its answer delay
// Notes: code lines toggle between answers so stale values never match
`timescale 1ns/1ns
module wpes_ep_model (
  input wire clk_i, input wire attempt_i, input wire [2:0] code_i, input wire [1:0] lat_i,
  output reg ready_o, output reg hs_valid_o, output reg [2:0] code_o, output reg tried_o
);
  reg [2:0] cnt = 3'h0;
  initial {ready_o, hs_valid_o, code_o, tried_o} = 6'h0;
  // one acceptance per attempt, answer after the delay; never a ready notice
  always @(posedge clk_i) begin
    ready_o <= attempt_i && !ready_o && cnt == 3'h0;
    hs_valid_o <= cnt == 3'h1;
    code_o <= (cnt == 3'h1) ? code_i : ~code_o;
    tried_o <= (cnt == 3'h1) | ~tried_o;
    if (ready_o && attempt_i) cnt <= {1'b0, lat_i} + 3'h2;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
  end
endmodule // wpes_ep_model

// File: tb/wpes_host_tb.sv
// Purpose: self-checking bench for the periodic pipe scheduler
// Assumes: the endpoint model answers every attempt
// Notes: interval length follows exp_i, held at 6 for the runs, so the run spans four intervals
`timescale 1ns/1ns
`include "wpes_defs.vh"
module wpes_host_tb;
  reg clk_i = 1'b0, rst_n_i = 1'b0, enable_i = 1'b0, dir_in_i = 1'b0;
  reg ctl_done_i = 1'b0, clear_halt_i = 1'b0, iso_i = 1'b0, low_power_i = 1'b0;
  reg [3:0] exp_i = 4'h6;
  reg [2:0] iso_slots_i = 3'h2, code = 3'h2;
  reg [1:0] lat = 2'h0;
  reg [31:0] r = 32'h0, cyc = 32'h0, last_iv = 32'h0;
  wire att, rdy, hs_v, tried, a_dir, win_rst, halted, bad_exp, iv;
  wire [2:0] hs_c;
  integer seed = 32'hd19e98a9, n_fail = 0, tests_run = 0, n, i;
  always #20 clk_i = ~clk_i;
  // cycle stamp for interval spacing
  always @(posedge clk_i) cyc <= cyc + 32'h1;
  wpes_host dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i), .exp_i(exp_i),
    .iso_i(iso_i), .low_power_i(low_power_i), .dir_in_i(dir_in_i), .iso_slots_i(iso_slots_i),
    .ctl_done_i(ctl_done_i), .clear_halt_i(clear_halt_i), .hs_valid_i(hs_v),
    .hs_code_i(hs_c), .dev_tried_i(tried), .attempt_o(att), .attempt_ready_i(rdy),
    .attempt_dir_o(a_dir), .win_reset_o(win_rst), .halted_o(halted), .bad_exp_o(bad_exp),
    .interval_o(iv));
  wpes_ep_model ep_u (.clk_i(clk_i), .attempt_i(att), .code_i(code), .lat_i(lat),
    .ready_o(rdy), .hs_valid_o(hs_v), .code_o(hs_c), .tried_o(tried));
  task check(input [31:0] want, input [31:0] got, input [63:0] nm);
    begin
      tests_run = tests_run + 1;
      if (got !== want) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s expected %0d seen %0d", nm, want, got);
      end
    end
  endtask
  // attempts per interval: std one plus retries, low power total, iso reserved slots but at least two
  function [31:0] exp_tries(input iso, input lp, input [2:0] slots);
    begin
      if (iso) exp_tries = (slots > 3'h1) ? {29'h0, slots} : 32'h2;
      else if (lp) exp_tries = {29'h0, `WPES_RETRY_LP};
      else exp_tries = {29'h0, `WPES_RETRY_STD} + 32'h1;
    end
  endfunction
  // interval in clock cycles for exponent x; 0 stands for 16
  function [31:0] iv_cycles(input [3:0] x);
    begin
      iv_cycles = (32'h1 << (x - 4'h1)) * `WPES_TICK_US * `WPES_CLK_MHZ;
    end
  endfunction
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // answer the next interval with c; acceptances are counted a half cycle early
  task run_iv(input [2:0] c, input [31:0] want, input [63:0] nm);
    begin
      @(posedge clk_i);
      code <= c;
      r = $random(seed);
      lat <= r[1:0];
      n = 0;
      @(negedge clk_i);
      while (iv !== 1'b1) @(negedge clk_i);
      if (last_iv != 32'h0) check(iv_cycles(exp_i), cyc - last_iv, "iv_len");
      last_iv = cyc;
      for (i = 0; i < 2000; i = i + 1) begin
        @(negedge clk_i);
        if (att && rdy) n = n + 1;
      end
      check(want, n, nm);
      $display("test %0s done", nm);
    end
  endtask
  // watchdog: four intervals of 32 ticks of 3200 cycles, plus margin
  initial begin
    repeat (450000) @(posedge clk_i);
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    r = $random(seed);
    exp_i <= 4'h1 + r[3:0] % 4'h5;
    dir_in_i <= r[4];
    iso_slots_i <= r[7:5];
    // the out-of-range flag only counts for an enabled pipe
    enable_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check(1, bad_exp, "exp_low");
    check(r[4], a_dir, "dir");
    @(posedge clk_i);
    exp_i <= `WPES_EXP_MAX;
    repeat (8) @(negedge clk_i);
    check(0, bad_exp, "exp16");
    @(posedge clk_i);
    exp_i <= `WPES_EXP_MIN;
    repeat (8) @(negedge clk_i);
    check(0, bad_exp, "exp_ok");
    @(posedge clk_i);
    ctl_done_i <= 1'b1;
    @(posedge clk_i);
    ctl_done_i <= 1'b0;
    low_power_i <= 1'b1;
    @(negedge clk_i);
    check(1, win_rst, "win_rst");
    run_iv(`WPES_HS_NAK, 1, "lp_nak");
    @(posedge clk_i);
    low_power_i <= 1'b0;
    run_iv(`WPES_HS_STALL, 1, "stall");
    check(1, halted, "halt");
    @(posedge clk_i);
    clear_halt_i <= 1'b1;
    @(posedge clk_i);
    clear_halt_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check(0, halted, "cleared");
    run_iv(`WPES_HS_ERR, exp_tries(1'b0, 1'b0, iso_slots_i), "err");
    check(1, halted, "err_halt");
    @(posedge clk_i);
    clear_halt_i <= 1'b1;
    iso_i <= 1'b1;
    r = $random(seed);
    iso_slots_i <= r[2:0];
    @(posedge clk_i);
    clear_halt_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    check(0, halted, "iso_clr");
    run_iv(r[3] ? `WPES_HS_ACK : `WPES_HS_SILENT,
           exp_tries(1'b1, 1'b0, r[2:0]), "iso");
    end_of_test;
  end
endmodule // wpes_host_tb
